// ==== hdl/basic_down_timer.v ====
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "basic_down_timer_defines.vh"
module basic_down_timer (
    input  wire        MCLK,
    input  wire        RST,
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    input  wire [3:0]  TIMER_IN,
    output reg  [3:0]  TIMER_OUT,
    output reg         IRQ
);
    localparam N = `BT_NUM_TIMERS;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode helpers.
    function [1:0] chan_of;
        input [7:0] a;
        begin
            chan_of = a[5:4];
        end
    endfunction

    function is_chan_reg;
        input [7:0] a;
        input [7:0] off;
        begin
            is_chan_reg = (a[7:6] == 2'b00) && ({4'h0, a[3:0]} == off);
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] d;
        input [3:0]  s;
        begin
            merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Internal clock divider: one tick every four clocks.
    reg [1:0] div_r;
    wire      int_tick = (div_r == 2'd3);
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            div_r <= 2'd0;
        end else begin
            div_r <= div_r + 2'd1; // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers.
    reg  [7:0]  ctrl_r   [0:N-1];
    reg  [15:0] presc_r  [0:N-1];
    reg  [15:0] reload_r [0:N-1];
    reg  [3:0]  start_set_r;
    reg  [3:0]  irq_stat_r;
    reg  [3:0]  irq_mask_r;
    wire [3:0]  running;
    wire [3:0]  eoc;
    wire [3:0]  tout;
    wire [15:0] count_w [0:N-1];
    wire [3:0]  in_lvl;
    wire [3:0]  in_fall;

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : ch
            input_edge_sync u_sync (
                .MCLK   (MCLK),
                .RST    (RST),
                .pin_in (TIMER_IN[g]),
                .level  (in_lvl[g]),
                .fall   (in_fall[g])
            );
            timer_channel u_tmr (
                .MCLK       (MCLK),
                .RST        (RST),
                .int_tick   (int_tick),
                .in_level   (in_lvl[g]),
                .in_fall    (in_fall[g]),
                .ctrl       (ctrl_r[g]),
                .presc_val  (presc_r[g]),
                .reload_val (reload_r[g]),
                .start_set  (start_set_r[g]),
                .running_r  (running[g]),
                .count_r    (count_w[g]),
                .out_r      (tout[g]),
                .eoc        (eoc[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.
    reg  [7:0]  awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         aw_have_r;
    reg         w_have_r;
    wire        aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    wire        w_take  = S_AXI_WVALID & S_AXI_WREADY;
    wire        do_write = aw_have_r & w_have_r & ~S_AXI_BVALID;
    wire [1:0]  wch = chan_of(awaddr_r);
    wire        w_ctrl   = is_chan_reg(awaddr_r, `BT_OFF_CTRL);
    wire        w_presc  = is_chan_reg(awaddr_r, `BT_OFF_PRESC);
    wire        w_reload = is_chan_reg(awaddr_r, `BT_OFF_RELOAD);
    wire        w_count  = is_chan_reg(awaddr_r, `BT_OFF_COUNT);
    wire        w_stat   = (awaddr_r == `BT_OFF_IRQ_STATUS);
    wire        w_mask   = (awaddr_r == `BT_OFF_IRQ_MASK);
    wire        w_ok     = w_ctrl | w_presc | w_reload | w_count | w_stat | w_mask;
    reg  [3:0]  stat_clr;

    always @* begin
        stat_clr = 4'h0;
        if (do_write && w_stat && wstrb_r[0]) begin
            stat_clr = wdata_r[3:0];
        end
    end

    integer i;
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `BT_RESP_OKAY;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            start_set_r   <= 4'h0;
            irq_mask_r    <= 4'h0;
            for (i = 0; i < N; i = i + 1) begin
                ctrl_r[i]   <= `BT_CTRL_RESET;
                presc_r[i]  <= `BT_PRESC_RESET;
                reload_r[i] <= `BT_RELOAD_RESET;
            end
        end else begin
            S_AXI_AWREADY <= ~aw_have_r & ~S_AXI_AWREADY & S_AXI_AWVALID;
            S_AXI_WREADY  <= ~w_have_r & ~S_AXI_WREADY & S_AXI_WVALID;
            if (aw_take) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_have_r <= 1'b1;
                wdata_r  <= S_AXI_WDATA;
                wstrb_r  <= S_AXI_WSTRB;
            end
            start_set_r <= 4'h0;
            for (i = 0; i < N; i = i + 1) begin
                if (running[i] == 1'b0 && start_set_r[i] == 1'b0) begin
                    ctrl_r[i][`BT_CTRL_START] <= 1'b0; // R5
                end
            end
            if (do_write) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= w_ok ? `BT_RESP_OKAY : `BT_RESP_SLVERR;
                if (w_ctrl && wstrb_r[0]) begin
                    ctrl_r[wch] <= wdata_r[7:0];
                    start_set_r[wch] <= wdata_r[`BT_CTRL_START] & ~ctrl_r[wch][`BT_CTRL_START]; // R5
                end
                if (w_presc) begin
                    presc_r[wch] <= merge16(presc_r[wch], wdata_r, wstrb_r); // R7
                end
                if (w_reload) begin
                    reload_r[wch] <= merge16(reload_r[wch], wdata_r, wstrb_r); // R7
                end
                if (w_mask && wstrb_r[0]) begin
                    irq_mask_r <= wdata_r[3:0];
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: a new end of count wins over a clear in the same cycle.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irq_stat_r <= 4'h0;
            IRQ        <= 1'b0;
            TIMER_OUT  <= 4'hF;
        end else begin
            irq_stat_r <= (irq_stat_r & ~stat_clr) | eoc; // R4 R16
            IRQ        <= |(((irq_stat_r & ~stat_clr) | eoc) & irq_mask_r);
            TIMER_OUT  <= tout; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.
    wire [1:0] rch = chan_of(S_AXI_ARADDR);
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `BT_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= `BT_RESP_OKAY;
                if (is_chan_reg(S_AXI_ARADDR, `BT_OFF_CTRL)) begin
                    S_AXI_RDATA <= {24'h00_0000, ctrl_r[rch]};
                end else if (is_chan_reg(S_AXI_ARADDR, `BT_OFF_PRESC)) begin
                    S_AXI_RDATA <= {16'h0000, presc_r[rch]};
                end else if (is_chan_reg(S_AXI_ARADDR, `BT_OFF_RELOAD)) begin
                    S_AXI_RDATA <= {16'h0000, reload_r[rch]};
                end else if (is_chan_reg(S_AXI_ARADDR, `BT_OFF_COUNT)) begin
                    S_AXI_RDATA <= {16'h0000, count_w[rch]};
                end else if (S_AXI_ARADDR == `BT_OFF_IRQ_STATUS) begin
                    S_AXI_RDATA <= {28'h000_0000, irq_stat_r};
                end else if (S_AXI_ARADDR == `BT_OFF_IRQ_MASK) begin
                    S_AXI_RDATA <= {28'h000_0000, irq_mask_r};
                end else begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= `BT_RESP_SLVERR;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule // basic_down_timer
`default_nettype wire

// ==== hdl/basic_down_timer_defines.vh ====
// Function
// R1: Four timers, each a 16-bit prescaler feeding a 16-bit down counter, single or continuous.
// R2: Prescaler clock is internal clock divided by 4 or the timer input pin.
// R3: External source keeps timer input frequency at most internal clock divided by 8.
// R4: Counter underflow at zero is end of count and raises an interrupt request.
// R5: Single mode: at end of count halt, reload, clear start bit; setting restarts.
// R6: Continuous mode: at end of count reload and keep counting until start bit cleared.
// R7: Software loads prescaler and counter before starting, else reset values are used.
// R8: Event counter mode counts one event per falling edge of the timer input.
// R9: External source spaces falling edges by at least eight internal clock cycles.
// R10: Gated mode counts internal clock while input high, holds while input low.
// R11: Triggerable mode starts once after enable and a falling edge; rearm by software.
// R12: Retriggerable mode restarts from loaded constants on every further falling edge.
// R13: No-output mode holds the timer output high, also its reset state.
// R14: Square wave mode inverts the output on every end of count.
// R15: PWM mode drives the output to the software forced level at end of count.
// R16: Counter constant zero stops counting but keeps the interrupt request asserted.
// R17: Timer input is synchronised by two flip-flops; falling edge is a one-cycle pulse.
`ifndef BASIC_DOWN_TIMER_DEFINES_VH
`define BASIC_DOWN_TIMER_DEFINES_VH
`define BT_NUM_TIMERS      4
`define BT_STRIDE          8'h10
`define BT_OFF_CTRL        8'h00
`define BT_OFF_PRESC       8'h04
`define BT_OFF_RELOAD      8'h08
`define BT_OFF_COUNT       8'h0C
`define BT_OFF_IRQ_STATUS  8'h40
`define BT_OFF_IRQ_MASK    8'h44
`define BT_CTRL_START      0
`define BT_CTRL_CONT       1
`define BT_CTRL_INPUT_EN   2
`define BT_CTRL_INMD_LO    3
`define BT_CTRL_INMD_HI    4
`define BT_CTRL_OUTMD_LO   5
`define BT_CTRL_OUTMD_HI   6
`define BT_CTRL_FORCE_LVL  7
`define BT_CTRL_WIDTH      8
`define BT_CTRL_RESET      8'h00
`define BT_PRESC_RESET     16'h0000
`define BT_RELOAD_RESET    16'hFFFF
`define BT_INT_DIV         4
`define BT_RESP_OKAY       2'b00
`define BT_RESP_SLVERR     2'b10
`endif

// ==== hdl/input_edge_sync.v ====
`timescale 1ns/10ps
`default_nettype none
module input_edge_sync (
    input  wire MCLK,
    input  wire RST,
    input  wire pin_in,
    output wire level,
    output wire fall
);
    reg meta_r;
    reg sync_r;
    reg prev_r;
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pin_in; // R17
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    assign level = sync_r;
    assign fall  = prev_r & ~sync_r; // R17
endmodule // input_edge_sync
`default_nettype wire

// ==== hdl/timer_channel.v ====
`timescale 1ns/10ps
`default_nettype none
`include "basic_down_timer_defines.vh"
module timer_channel (
    input  wire        MCLK,
    input  wire        RST,
    input  wire        int_tick,
    input  wire        in_level,
    input  wire        in_fall,
    input  wire [7:0]  ctrl,
    input  wire [15:0] presc_val,
    input  wire [15:0] reload_val,
    input  wire        start_set,
    output reg         running_r,
    output reg  [15:0] count_r,
    output reg         out_r,
    output wire        eoc
);
    localparam MODE_EVENT = 2'd0;
    localparam MODE_GATED = 2'd1;
    localparam MODE_TRIG  = 2'd2;
    localparam MODE_RETRG = 2'd3;
    localparam OUT_NONE   = 2'd0;
    localparam OUT_SQUARE = 2'd1;

    reg  [15:0] pre_r;
    reg         armed_r;
    wire [1:0]  in_mode  = {ctrl[`BT_CTRL_INMD_HI], ctrl[`BT_CTRL_INMD_LO]};
    wire [1:0]  out_mode = {ctrl[`BT_CTRL_OUTMD_HI], ctrl[`BT_CTRL_OUTMD_LO]};
    wire        use_in   = ctrl[`BT_CTRL_INPUT_EN];
    wire        zero_cst = (reload_val == 16'h0000);
    reg         tick;
    wire        go       = running_r & armed_r & ~zero_cst; // R16
    wire        pre_wrap = go & tick & (pre_r == 16'h0000);
    wire        underflow = pre_wrap & (count_r == 16'h0000); // R4
    wire        retrig   = running_r & use_in & (in_mode == MODE_RETRG) & in_fall & armed_r; // R12
    assign eoc = underflow | (running_r & zero_cst); // R4 R16

    always @* begin
        if (!use_in) begin
            tick = int_tick; // R2
        end else if (in_mode == MODE_EVENT) begin
            tick = in_fall; // R2 R8
        end else if (in_mode == MODE_GATED) begin
            tick = int_tick & in_level; // R10
        end else begin
            tick = int_tick;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            running_r <= 1'b0;
            armed_r   <= 1'b0;
            pre_r     <= `BT_PRESC_RESET;
            count_r   <= `BT_RELOAD_RESET;
            out_r     <= 1'b1; // R13
        end else begin
            if (start_set) begin
                running_r <= 1'b1; // R5
                armed_r   <= ~(use_in & in_mode[1]); // R11
                pre_r     <= presc_val; // R7
                count_r   <= reload_val;
            end else if (!ctrl[`BT_CTRL_START]) begin
                running_r <= 1'b0; // R6
            end else if (running_r & ~armed_r & in_fall) begin
                armed_r <= 1'b1; // R11
            end else if (retrig) begin
                pre_r   <= presc_val; // R12
                count_r <= reload_val;
            end else if (underflow) begin
                pre_r   <= presc_val;
                count_r <= reload_val; // R5 R6
                if (!ctrl[`BT_CTRL_CONT]) begin
                    running_r <= 1'b0; // R5 R11
                end
            end else if (go & tick) begin
                if (pre_wrap) begin
                    pre_r   <= presc_val;
                    count_r <= count_r - 16'h0001; // R1
                end else begin
                    pre_r <= pre_r - 16'h0001; // R1
                end
            end
            if (out_mode == OUT_NONE) begin
                out_r <= 1'b1; // R13
            end else if (underflow) begin
                if (out_mode == OUT_SQUARE) begin
                    out_r <= ~out_r; // R14
                end else begin
                    out_r <= ctrl[`BT_CTRL_FORCE_LVL]; // R15
                end
            end
        end
    end
endmodule // timer_channel
`default_nettype wire

// ==== verif/timer_input_source.sv ====
`timescale 1ns/10ps
`default_nettype none
module timer_input_source (
    input  wire logic       MCLK,
    output var  logic [3:0] PINS
);
    initial PINS = 4'hF;

    // Pins idle high, and falls are never closer than eight clocks.
    task automatic pulse(input int ch, input int n, input int gap);
        int g;
        g = (gap < 8) ? 8 : gap;
        repeat (n) begin
            @(posedge MCLK) PINS[ch] <= 1'b0;
            repeat (g / 2) @(posedge MCLK);
            PINS[ch] <= 1'b1;
            repeat (g - g / 2) @(posedge MCLK);
        end
    endtask

    task automatic level(input int ch, input logic v);
        @(posedge MCLK) PINS[ch] <= v;
    endtask
endmodule // timer_input_source
`default_nettype wire

// ==== verif/basic_down_timer_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module basic_down_timer_asserts (
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic [3:0]  TIMER_OUT,
    input wire logic        IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data not held");
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    aw_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("write address ready not a pulse");
    refused_zero_a: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'b10 |-> S_AXI_RDATA == 32'h0000_0000)
        else $error("refused read returns data");
    bresp_code_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'b00 || S_AXI_BRESP == 2'b10)
        else $error("bad write response code");
    out_reset_a: assert property ($fell(RST) |-> TIMER_OUT == 4'hF)
        else $error("timer output not high after reset");
    irq_reset_a: assert property ($fell(RST) |-> !IRQ)
        else $error("interrupt high after reset");
endmodule // basic_down_timer_asserts

bind basic_down_timer basic_down_timer_asserts u_asserts (.MCLK(MCLK), .RST(RST), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .TIMER_OUT(TIMER_OUT), .IRQ(IRQ));
`default_nettype wire

// ==== verif/basic_down_timer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module basic_down_timer_tb;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, rr;
    logic [31:0] rdata, rdat;
    logic [3:0]  tin, tout;
    int          err_count = 0;
    int          total_checks = 0;
    int          cyc = 0;

    always #10 mclk = ~mclk;

    basic_down_timer u_dut (.MCLK(mclk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TIMER_IN(tin),
        .TIMER_OUT(tout), .IRQ(irq));
    timer_input_source u_src (.MCLK(mclk), .PINS(tin));

    ////////////////////////////////////////////////////////////////////////////
    task summarize();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function logic [15:0] z(input logic x);
        return {15'h0000, x};
    endfunction

    // Ready is raised one cycle after the answer so that the hold checks see a stalled response.
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        rr = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        rdat = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask

    // Polls the status register until the timer's end-of-count bit shows.
    task ws(input int ch);
        int i;
        for (i = 0; i < 100; i++) begin
            rd(8'h40);
            if (rdat[ch] === 1'b1) break;
        end
        chk(z(rdat[ch]), 16'h0001);
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h04); chk(rdat[15:0], 16'h0000);
        rd(8'h08); chk(rdat[15:0], 16'hFFFF);
        rd(8'h50); chk({14'h0000, rr}, 16'h0002);
        wr(8'h44, 16'h000F);
        chk({14'h0000, rr}, 16'h0000);
        wr(8'h50, 16'h0000);
        chk({14'h0000, rr}, 16'h0002);
        $display("test reset values done");
        wr(8'h08, 16'h0003);
        wr(8'h00, 16'h0001);
        ws(0);
        chk(z(irq), 16'h0001);
        rd(8'h00); chk(rdat[15:0], 16'h0000);
        rd(8'h0C); chk(rdat[15:0], 16'h0003);
        chk(z(tout[0]), 16'h0001);
        wr(8'h40, 16'h0001);
        repeat (2) @(posedge mclk);
        chk(z(irq), 16'h0000);
        wr(8'h00, 16'h0001);
        ws(0);
        $display("test single mode done");
        wr(8'h18, 16'h0010);
        wr(8'h10, 16'h0023);
        ws(1);
        chk(z(tout[1]), 16'h0000);
        wr(8'h40, 16'h0002);
        ws(1);
        chk(z(tout[1]), 16'h0001);
        rd(8'h10); chk(rdat[15:0], 16'h0023);
        wr(8'h10, 16'h00C3);
        wr(8'h40, 16'h0002);
        ws(1);
        chk(z(tout[1]), 16'h0001);
        wr(8'h10, 16'h0043);
        wr(8'h40, 16'h0002);
        ws(1);
        chk(z(tout[1]), 16'h0000);
        wr(8'h10, 16'h0000);
        $display("test continuous and output modes done");
        wr(8'h28, 16'h0005);
        wr(8'h24, 16'h0001);
        wr(8'h20, 16'h0005);
        repeat (40) @(posedge mclk);
        rd(8'h2C); chk(rdat[15:0], 16'h0005);
        u_src.pulse(2, 3, 10);
        repeat (8) @(posedge mclk);
        rd(8'h2C); chk(rdat[15:0], 16'h0004);
        $display("test event counter done");
        u_src.level(3, 1'b0);
        wr(8'h38, 16'h0100);
        wr(8'h30, 16'h000D);
        repeat (40) @(posedge mclk);
        rd(8'h3C); chk(rdat[15:0], 16'h0100);
        u_src.level(3, 1'b1);
        repeat (40) @(posedge mclk);
        rd(8'h3C); chk(z(rdat[15:0] < 16'h0100), 16'h0001);
        u_src.level(3, 1'b0);
        repeat (8) @(posedge mclk);
        rd(8'h3C);
        wdata <= rdat;
        repeat (40) @(posedge mclk);
        rd(8'h3C); chk(rdat[15:0], wdata[15:0]);
        $display("test gated done");
        wr(8'h30, 16'h0000);
        u_src.level(3, 1'b1);
        wr(8'h30, 16'h0015);
        repeat (40) @(posedge mclk);
        rd(8'h3C); chk(rdat[15:0], 16'h0100);
        u_src.pulse(3, 1, 10);
        repeat (40) @(posedge mclk);
        rd(8'h3C); chk(z(rdat[15:0] < 16'h0100), 16'h0001);
        wr(8'h30, 16'h0000);
        wr(8'h30, 16'h001D);
        u_src.pulse(3, 1, 10);
        repeat (400) @(posedge mclk);
        rd(8'h3C); chk(z(rdat[15:0] < 16'h00B0), 16'h0001);
        u_src.pulse(3, 1, 10);
        rd(8'h3C); chk(z(rdat[15:0] > 16'h00F0), 16'h0001);
        wr(8'h30, 16'h0000);
        $display("test trigger modes done");
        wr(8'h08, 16'h0000);
        wr(8'h00, 16'h0001);
        wr(8'h40, 16'h000F);
        rd(8'h40); chk(z(rdat[0]), 16'h0001);
        rd(8'h0C); chk(rdat[15:0], 16'h0000);
        wr(8'h44, 16'h0000);
        repeat (2) @(posedge mclk);
        chk(z(irq), 16'h0000);
        wr(8'h44, 16'h000F);
        repeat (2) @(posedge mclk);
        chk(z(irq), 16'h0001);
        $display("test zero constant and mask done");
        summarize();
    end
endmodule // basic_down_timer_tb
`default_nettype wire
